/* File: cbd_alu16.sv */
// Purpose: 16-bit add, add-with-carry and subtract-with-borrow with flags
// Assumes: purely combinational, used by the core in the decode cycle
// Notes:   plain add leaves sign, zero and parity/overflow untouched
`default_nettype none

module cbd_alu16 import cbd_pkg::*; (
	input  wire cbd_a16_t    kind,
	input  wire logic [15:0] lhs,
	input  wire logic [15:0] rhs,
	input  wire logic [7:0]  f_in,
	output logic      [15:0] res,
	output logic      [7:0]  f_out
);

	logic [16:0] sum;   // result with carry out
	logic [12:0] half;  // low twelve bits for half carry
	logic        cin;   // carry or borrow in
	logic        ovf;   // signed overflow

	// arithmetic and flag update
	always_comb begin
		cin = (kind != A16_ADD) && f_in[FLAG_C];
		if (kind == A16_SBC) begin
			sum  = {1'b0, lhs} - {1'b0, rhs} - 17'(cin);
			half = {1'b0, lhs[11:0]} - {1'b0, rhs[11:0]} - 13'(cin);
			ovf  = (lhs[15] != rhs[15]) && (sum[15] != lhs[15]);
		end else begin
			sum  = {1'b0, lhs} + {1'b0, rhs} + 17'(cin);
			half = {1'b0, lhs[11:0]} + {1'b0, rhs[11:0]} + 13'(cin);
			ovf  = (lhs[15] == rhs[15]) && (sum[15] != lhs[15]);
		end
		res = sum[15:0];
		f_out = f_in;
		f_out[FLAG_C] = sum[16];
		f_out[FLAG_H] = half[12];
		f_out[FLAG_N] = (kind == A16_SBC);
		// only the carry forms touch the full flag set
		if (kind != A16_ADD) begin
			f_out[FLAG_S]  = sum[15];
			f_out[FLAG_Z]  = (sum[15:0] == 16'h0000);
			f_out[FLAG_PV] = ovf;
		end
	end

endmodule

`default_nettype wire

/* File: cbd_bitrot.sv */
// Purpose: rotates, shifts, bit test/clear/set and the digit rotates
// Assumes: op is the second opcode byte; digit selects the digit rotates
// Notes:   the spare shift code shifts a one in at the bottom
`default_nettype none

module cbd_bitrot import cbd_pkg::*; (
	input  wire logic [7:0] op,
	input  wire logic [7:0] val,
	input  wire logic [7:0] acc,
	input  wire logic [7:0] f_in,
	input  wire logic       digit,
	output logic      [7:0] res,
	output logic      [7:0] acc_res,
	output logic      [7:0] f_out,
	output logic            bit_val
);

	logic [2:0] sel;  // bit number or shift kind
	logic       cy;   // carry out of a rotate
	logic [7:0] fr;   // byte the flags describe

	// one operation per opcode byte
	always_comb begin
		sel = op[5:3];
		bit_val = val[sel];
		res = val;
		acc_res = acc;
		f_out = f_in;
		cy = f_in[FLAG_C];
		fr = val;
		if (digit) begin
			// digit rotates move nibbles between acc and memory
			if (op == OPX_RLD) begin
				res = {val[3:0], acc[3:0]};
				acc_res = {acc[7:4], val[7:4]};
			end else begin
				res = {acc[3:0], val[7:4]};
				acc_res = {acc[7:4], val[3:0]};
			end
			fr = acc_res;
		end else begin
			case (op[7:6])
				GRP_ROT: begin
					case (sel)
						3'h0: res = {val[6:0], val[7]};
						3'h1: res = {val[0], val[7:1]};
						3'h2: res = {val[6:0], f_in[FLAG_C]};
						3'h3: res = {f_in[FLAG_C], val[7:1]};
						3'h4: res = {val[6:0], 1'b0};
						3'h5: res = {val[7], val[7:1]};
						3'h6: res = {val[6:0], 1'b1};
						default: res = {1'b0, val[7:1]};
					endcase
					// left kinds shift out bit 7, right kinds bit 0
					cy = sel[0] ? val[0] : val[7];
					fr = res;
				end
				GRP_TEST: begin
					f_out[FLAG_Z] = !bit_val;
					f_out[FLAG_H] = 1'b1;
					f_out[FLAG_N] = 1'b0;
				end
				GRP_CLR: res[sel] = 1'b0;
				default: res[sel] = 1'b1;
			endcase
		end
		// shared flag form of rotates and digit rotates
		if (digit || op[7:6] == GRP_ROT) begin
			f_out[FLAG_S]  = fr[7];
			f_out[FLAG_Z]  = (fr == 8'h00);
			f_out[FLAG_H]  = 1'b0;
			f_out[FLAG_PV] = ~^fr;
			f_out[FLAG_N]  = 1'b0;
			f_out[FLAG_C]  = cy;
		end
	end

endmodule

`default_nettype wire

/* File: cbd_core.sv */
// Purpose: fetch, decode and execute of the arithmetic, bit and branch slice
// Assumes: memory acks each strobe once, rdata valid with the ack
// Notes:   strobes drop for one cycle after every ack
`default_nettype none

module cbd_core import cbd_pkg::*; (
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	input  wire logic [7:0]  bus_rdata,
	input  wire logic        bus_ack,
	output logic      [15:0] bus_addr,
	output logic             bus_rd,
	output logic             bus_wr,
	output logic      [7:0]  bus_wdata,
	output logic             irq_exit_pulse,
	output logic             bad_op_pulse,
	output logic      [7:0]  acc_out,
	output logic      [7:0]  flags_out
);

	// whole state of the core
	typedef struct packed {
		cbd_state_t  st;        // sequencer state
		logic [7:0]  a;         // accumulator
		logic [7:0]  f;         // flags
		logic [7:0]  b;         // counter pair high
		logic [7:0]  c;         // counter pair low
		logic [7:0]  d;         // target pair high
		logic [7:0]  e;         // target pair low
		logic [7:0]  h;         // pointer pair high
		logic [7:0]  l;         // pointer pair low
		logic [15:0] ix;        // first index register
		logic [15:0] iy;        // second index register
		logic [15:0] sp;        // stack pointer
		logic [15:0] pc;        // program counter
		logic [15:0] tmp;       // operand or displacement
		logic [15:0] addr;      // data memory address
		logic [7:0]  op;        // opcode in progress
		logic [1:0]  idx;       // index prefix seen
		logic        ed;        // extended prefix seen
		logic        cb;        // bit prefix seen
		logic [15:0] bus_addr;  // bus address out
		logic        bus_rd;    // read strobe
		logic        bus_wr;    // write strobe
		logic [7:0]  bus_wdata; // write data
		logic        irq_exit;  // interrupt return pulse
		logic        bad_op;    // unsupported opcode pulse
	} cbd_core_t;

	cbd_core_t q_reg;   // registered state
	cbd_core_t q_next;  // next state

	logic [7:0]  cur_op;    // opcode being worked on
	logic        fetch_ack; // opcode byte arrives
	logic [15:0] idx_reg;   // pointer pair or index chosen
	logic [15:0] hl_val;    // pointer pair as a word
	cbd_a16_t    a16_kind;  // arithmetic kind
	logic [15:0] a16_lhs;   // arithmetic destination
	logic [15:0] a16_rhs;   // arithmetic source
	logic [15:0] a16_res;   // arithmetic result
	logic [7:0]  a16_f;     // arithmetic flags
	logic [7:0]  br_val;    // bit unit operand
	logic [7:0]  br_res;    // bit unit result
	logic [7:0]  br_acc;    // digit rotate accumulator
	logic [7:0]  br_f;      // bit unit flags
	logic        br_bit;    // tested bit
	logic        done;      // instruction finished
	logic        is_rd;     // next state reads the bus
	logic        is_wr;     // next state writes the bus

	// operand register by operand code
	function automatic logic [7:0] reg8(input cbd_core_t s,
		input logic [2:0] code);
		case (code)
			3'h0: reg8 = s.b;
			3'h1: reg8 = s.c;
			3'h2: reg8 = s.d;
			3'h3: reg8 = s.e;
			3'h4: reg8 = s.h;
			3'h5: reg8 = s.l;
			default: reg8 = s.a;
		endcase
	endfunction

	// flag condition by condition code
	function automatic logic cond_ok(input logic [7:0] fl,
		input logic [2:0] cc);
		case (cc)
			3'h0: cond_ok = !fl[FLAG_Z];
			3'h1: cond_ok = fl[FLAG_Z];
			3'h2: cond_ok = !fl[FLAG_C];
			3'h3: cond_ok = fl[FLAG_C];
			3'h4: cond_ok = !fl[FLAG_PV];
			3'h5: cond_ok = fl[FLAG_PV];
			3'h6: cond_ok = !fl[FLAG_S];
			default: cond_ok = fl[FLAG_S];
		endcase
	endfunction

	// sign extension of a displacement byte
	function automatic logic [15:0] sext(input logic [7:0] v);
		sext = {{8{v[7]}}, v};
	endfunction

	// decode helpers shared by the units
	assign cur_op    = (q_reg.st == ST_FETCH) ? bus_rdata : q_reg.op;
	assign fetch_ack = (q_reg.st == ST_FETCH) && bus_ack;
	assign hl_val    = {q_reg.h, q_reg.l};
	assign idx_reg   = (q_reg.idx == IDX_1) ? q_reg.ix :
		(q_reg.idx == IDX_2) ? q_reg.iy : hl_val;

	// index prefix swaps destination and self-source
	assign a16_lhs = q_reg.ed ? hl_val : idx_reg;
	// pair order counter, target, pointer, stack
	assign a16_rhs = (cur_op[5:4] == 2'h0) ? {q_reg.b, q_reg.c} :
		(cur_op[5:4] == 2'h1) ? {q_reg.d, q_reg.e} :
		(cur_op[5:4] == 2'h2) ? a16_lhs : q_reg.sp;
	assign a16_kind = !q_reg.ed ? A16_ADD :
		(cur_op[3] ? A16_ADC : A16_SBC);

	// memory operand comes from the bus, others from registers
	assign br_val = (q_reg.st == ST_MEMRD) ? bus_rdata :
		reg8(q_reg, cur_op[2:0]);

	cbd_alu16 u_alu16 (
		.kind  (a16_kind),
		.lhs   (a16_lhs),
		.rhs   (a16_rhs),
		.f_in  (q_reg.f),
		.res   (a16_res),
		.f_out (a16_f)
	);

	cbd_bitrot u_bitrot (
		.op      (cur_op),
		.val     (br_val),
		.acc     (q_reg.a),
		.f_in    (q_reg.f),
		.digit   (q_reg.ed),
		.res     (br_res),
		.acc_res (br_acc),
		.f_out   (br_f),
		.bit_val (br_bit)
	);

	// sequencer: every state waits for the ack of its bus access
	always_comb begin
		q_next = q_reg;
		q_next.irq_exit = 1'b0;
		q_next.bad_op = 1'b0;
		done = 1'b0;
		is_rd = 1'b0;
		is_wr = 1'b0;
		if (bus_ack) begin
			case (q_reg.st)
				ST_FETCH: begin
					q_next.pc = q_reg.pc + 16'h0001;
					q_next.op = bus_rdata;
					if (!q_reg.ed && !q_reg.cb &&
						(bus_rdata == OP_PFX_IDX1 || bus_rdata == OP_PFX_IDX2)) begin
						q_next.idx = (bus_rdata == OP_PFX_IDX1) ? IDX_1 : IDX_2;
					end else if (!q_reg.ed && !q_reg.cb &&
						bus_rdata == OP_PFX_EXT) begin
						q_next.ed = 1'b1;
					end else if (!q_reg.ed && !q_reg.cb &&
						bus_rdata == OP_PFX_BIT) begin
						if (q_reg.idx != IDX_NONE) begin
							q_next.st = ST_DISP;
						end else begin
							q_next.cb = 1'b1;
						end
					end else if (q_reg.cb) begin
						// operand code 6 names memory at pointer
						if (bus_rdata[2:0] == OPND_MEM) begin
							q_next.addr = hl_val;
							q_next.st = ST_MEMRD;
						end else begin
							q_next.f = br_f;
							if (bus_rdata[7:6] != GRP_TEST) begin
								case (bus_rdata[2:0])
									3'h0: q_next.b = br_res;
									3'h1: q_next.c = br_res;
									3'h2: q_next.d = br_res;
									3'h3: q_next.e = br_res;
									3'h4: q_next.h = br_res;
									3'h5: q_next.l = br_res;
									default: q_next.a = br_res;
								endcase
							end
							done = 1'b1;
						end
					end else if (q_reg.ed) begin
						if ((bus_rdata & MASK_PAIR) == PAT_ADC16 ||
							(bus_rdata & MASK_PAIR) == PAT_SBC16) begin
							{q_next.h, q_next.l} = a16_res;
							q_next.f = a16_f;
							done = 1'b1;
						end else if (bus_rdata == OPX_IRQ_EXIT_JUMP) begin
							q_next.irq_exit = 1'b1;
							q_next.st = ST_POPL;
						end else if (bus_rdata == OPX_NMI_EXIT_JUMP) begin
							q_next.st = ST_POPL;
						end else if (bus_rdata == OPX_RRD ||
							bus_rdata == OPX_RLD) begin
							q_next.addr = hl_val;
							q_next.st = ST_MEMRD;
						end else begin
							q_next.bad_op = 1'b1;
							done = 1'b1;
						end
					end else if ((bus_rdata & MASK_PAIR) == PAT_ADD16) begin
						// plain add, result to chosen destination
						case (q_reg.idx)
							IDX_1: q_next.ix = a16_res;
							IDX_2: q_next.iy = a16_res;
							default: {q_next.h, q_next.l} = a16_res;
						endcase
						q_next.f = a16_f;
						done = 1'b1;
					end else if (bus_rdata == OP_JP || bus_rdata == OP_CALL ||
						bus_rdata == OP_JR ||
						(bus_rdata & MASK_CC) == PAT_JPCC ||
						(bus_rdata & MASK_CC) == PAT_CALLCC ||
						(bus_rdata & MASK_JRCC) == PAT_JRCC) begin
						// operand bytes follow the opcode
						q_next.st = ST_OPLO;
					end else if (bus_rdata == OP_JPIND) begin
						// pair copied straight into the counter
						q_next.pc = idx_reg;
						done = 1'b1;
					end else if (bus_rdata == OP_RET ||
						((bus_rdata & MASK_CC) == PAT_RETCC &&
						cond_ok(q_reg.f, bus_rdata[5:3]))) begin
						q_next.st = ST_POPL;
					end else if ((bus_rdata & MASK_CC) == PAT_RETCC) begin
						done = 1'b1;
					end else begin
						// outside this slice: flagged and skipped
						q_next.bad_op = 1'b1;
						done = 1'b1;
					end
				end
				ST_DISP: begin
					q_next.pc = q_reg.pc + 16'h0001;
					q_next.tmp = sext(bus_rdata);
					q_next.st = ST_OPCB;
				end
				ST_OPCB: begin
					q_next.pc = q_reg.pc + 16'h0001;
					q_next.op = bus_rdata;
					q_next.cb = 1'b1;
					q_next.addr = idx_reg + q_reg.tmp;
					q_next.st = ST_MEMRD;
				end
				ST_OPLO: begin
					q_next.pc = q_reg.pc + 16'h0001;
					q_next.tmp[7:0] = bus_rdata;
					if (q_reg.op == OP_JR ||
						(q_reg.op & MASK_JRCC) == PAT_JRCC) begin
						if (q_reg.op == OP_JR ||
							cond_ok(q_reg.f, {1'b0, q_reg.op[4:3]})) begin
							q_next.pc = q_reg.pc + 16'h0001 + sext(bus_rdata);
						end
						done = 1'b1;
					end else begin
						q_next.st = ST_OPHI;
					end
				end
				ST_OPHI: begin
					// high byte second, low kept from before
					q_next.pc = q_reg.pc + 16'h0001;
					q_next.tmp = {bus_rdata, q_reg.tmp[7:0]};
					if (q_reg.op == OP_CALL ||
						((q_reg.op & MASK_CC) == PAT_CALLCC &&
						cond_ok(q_reg.f, q_reg.op[5:3]))) begin
						q_next.sp = q_reg.sp - 16'h0001;
						q_next.st = ST_PUSHH;
					end else begin
						if (q_reg.op == OP_JP || ((q_reg.op & MASK_CC) ==
							PAT_JPCC && cond_ok(q_reg.f, q_reg.op[5:3]))) begin
							q_next.pc = {bus_rdata, q_reg.tmp[7:0]};
						end
						done = 1'b1;
					end
				end
				ST_PUSHH: begin
					q_next.sp = q_reg.sp - 16'h0001;
					q_next.st = ST_PUSHL;
				end
				ST_PUSHL: begin
					// jump only after both bytes are stacked
					q_next.pc = q_reg.tmp;
					done = 1'b1;
				end
				ST_POPL: begin
					q_next.tmp[7:0] = bus_rdata;
					q_next.sp = q_reg.sp + 16'h0001;
					q_next.st = ST_POPH;
				end
				ST_POPH: begin
					q_next.pc = {bus_rdata, q_reg.tmp[7:0]};
					q_next.sp = q_reg.sp + 16'h0001;
					done = 1'b1;
				end
				ST_MEMRD: begin
					q_next.f = br_f;
					q_next.bus_wdata = br_res;
					if (q_reg.ed) begin
						q_next.a = br_acc;
						q_next.st = ST_MEMWR;
					end else if (q_reg.op[7:6] == GRP_TEST) begin
						done = 1'b1;
					end else begin
						q_next.st = ST_MEMWR;
					end
				end
				ST_MEMWR: done = 1'b1;
				default: done = 1'b1;
			endcase
		end
		// prefixes only live for one instruction
		if (done) begin
			q_next.st = ST_FETCH;
			q_next.idx = IDX_NONE;
			q_next.ed = 1'b0;
			q_next.cb = 1'b0;
		end
		// bus access of the next state
		case (q_next.st)
			ST_MEMRD: begin
				q_next.bus_addr = q_next.addr;
				is_rd = 1'b1;
			end
			ST_MEMWR: begin
				q_next.bus_addr = q_next.addr;
				is_wr = 1'b1;
			end
			ST_PUSHH: begin
				q_next.bus_addr = q_next.sp;
				q_next.bus_wdata = q_next.pc[15:8];
				is_wr = 1'b1;
			end
			ST_PUSHL: begin
				q_next.bus_addr = q_next.sp;
				q_next.bus_wdata = q_next.pc[7:0];
				is_wr = 1'b1;
			end
			ST_POPL, ST_POPH: begin
				q_next.bus_addr = q_next.sp;
				is_rd = 1'b1;
			end
			default: begin
				q_next.bus_addr = q_next.pc;
				is_rd = 1'b1;
			end
		endcase
		// gap after each ack so one strobe means one transfer
		q_next.bus_rd = is_rd && !bus_ack;
		q_next.bus_wr = is_wr && !bus_ack;
		// synchronous reset: everything clear, stack at top
		if (!rst_n) begin
			q_next = '0;
			q_next.pc = PC_RESET;
			q_next.sp = SP_RESET;
		end
	end

	// single state register
	always_ff @(posedge core_clk) begin
		q_reg <= q_next;
	end

	// outputs straight from the state register
	assign bus_addr       = q_reg.bus_addr;
	assign bus_rd         = q_reg.bus_rd;
	assign bus_wr         = q_reg.bus_wr;
	assign bus_wdata      = q_reg.bus_wdata;
	assign irq_exit_pulse = q_reg.irq_exit;
	assign bad_op_pulse   = q_reg.bad_op;
	assign acc_out        = q_reg.a;
	assign flags_out      = q_reg.f;

	default clocking dflt @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// strobes fall after every ack
	a_strobe_gap: assert property (bus_ack |=> !bus_rd && !bus_wr)
		else $error("strobe held past ack");
	a_add_pair: assert property (
		fetch_ack && !q_reg.ed && !q_reg.cb && q_reg.idx == IDX_NONE &&
		(bus_rdata & MASK_PAIR) == PAT_ADD16 |=>
		{q_reg.h, q_reg.l} == $past(hl_val) + $past(a16_rhs))
		else $error("pair add result wrong");
	a_bit_zero: assert property (
		fetch_ack && q_reg.cb && bus_rdata[7:6] == GRP_TEST &&
		bus_rdata[2:0] != OPND_MEM |=> flags_out[FLAG_Z] == !$past(br_bit))
		else $error("bit test zero flag wrong");
	// the write strobe only rises after the idle cycle that follows the ack
	a_clear_bit: assert property (
		q_reg.st == ST_MEMRD && bus_ack && q_reg.cb && !q_reg.ed &&
		q_reg.op[7:6] == GRP_CLR |-> ##2 bus_wr &&
		!bus_wdata[$past(q_reg.op[5:3], 2)])
		else $error("cleared bit still set");
	a_jp_skip: assert property (
		q_reg.st == ST_OPHI && bus_ack &&
		(q_reg.op & MASK_CC) == PAT_JPCC &&
		!cond_ok(q_reg.f, q_reg.op[5:3]) |=>
		q_reg.pc == $past(q_reg.pc) + 16'h0001 && q_reg.st == ST_FETCH)
		else $error("untaken jump moved counter");
	a_jr_target: assert property (
		q_reg.st == ST_OPLO && bus_ack && q_reg.op == OP_JR |=>
		q_reg.pc == $past(q_reg.pc) + 16'h0001 + sext($past(bus_rdata)))
		else $error("relative target wrong");
	a_call_push: assert property (
		q_reg.st == ST_PUSHH && bus_wr |->
		bus_wdata == q_reg.pc[15:8] && bus_addr == q_reg.sp)
		else $error("call pushed wrong byte");
	a_ret_pop: assert property (
		fetch_ack && !q_reg.ed && !q_reg.cb && bus_rdata == OP_RET |=>
		q_reg.st == ST_POPL ##1 bus_rd && bus_addr == $past(q_reg.sp, 2))
		else $error("return did not pop");
	a_irq_exit: assert property (
		irq_exit_pulse |-> q_reg.st == ST_POPL && !$past(irq_exit_pulse))
		else $error("interrupt return pulse misplaced");

endmodule

`default_nettype wire

/* File: cbd_mem.sv */
// Purpose: program memory and a watching peripheral for the core
// Assumes: one strobe at a time, lag idle cycles before each ack
// Notes:   idle rdata toggles so a stale byte is never mistaken
`default_nettype none
module cbd_mem (
	input  wire logic        core_clk,
	input  wire logic [15:0] bus_addr,
	input  wire logic        bus_rd,
	input  wire logic        bus_wr,
	input  wire logic [7:0]  bus_wdata,
	input  wire logic        irq_exit_pulse,
	input  wire logic [1:0]  lag,
	output var  logic        bus_ack,
	output var  logic [7:0]  bus_rdata,
	output var  int          exit_count
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:65535]; // byte store
	logic [1:0] wait_cnt;      // cycles waited on this strobe
	initial begin
		foreach (mem[i]) mem[i] = 8'hFF;
		bus_ack = 1'b0;
		bus_rdata = 8'h00;
		wait_cnt = 2'h0;
		exit_count = 0;
	end
	// one ack per strobe; the guard stops a second ack on a held strobe
	always @(posedge core_clk) begin
		bus_ack <= 1'b0;
		bus_rdata <= ~bus_rdata;
		if ((bus_rd || bus_wr) && !bus_ack) begin
			if (wait_cnt == lag) begin
				bus_ack <= 1'b1;
				wait_cnt <= 2'h0;
				bus_rdata <= mem[bus_addr];
				if (bus_wr) mem[bus_addr] <= bus_wdata;
			end else
				wait_cnt <= wait_cnt + 2'h1;
		end
		if (irq_exit_pulse) exit_count <= exit_count + 1;
	end
endmodule
`default_nettype wire

/* File: cbd_pkg.sv */
// Purpose: shared constants and types of the arithmetic, bit and branch core
// Assumes: byte-wide program memory on the same clock as the core
// Notes:   opcodes, masks, operand codes and bit-group codes are the numbers the decoder compares
`default_nettype none

package cbd_pkg;

	// reset values of the program counter and stack pointer
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] SP_RESET = 16'hFFFF;

	// flag bit positions inside the flag register
	localparam int FLAG_S  = 7;
	localparam int FLAG_Z  = 6;
	localparam int FLAG_H  = 4;
	localparam int FLAG_PV = 2;
	localparam int FLAG_N  = 1;
	localparam int FLAG_C  = 0;

	// prefix bytes
	localparam logic [7:0] OP_PFX_IDX1 = 8'hDD;
	localparam logic [7:0] OP_PFX_IDX2 = 8'hFD;
	localparam logic [7:0] OP_PFX_EXT  = 8'hED;
	localparam logic [7:0] OP_PFX_BIT  = 8'hCB;

	// single opcodes
	localparam logic [7:0] OP_JP    = 8'hC3;
	localparam logic [7:0] OP_JR    = 8'h18;
	localparam logic [7:0] OP_JPIND = 8'hE9;
	localparam logic [7:0] OP_CALL  = 8'hCD;
	localparam logic [7:0] OP_RET   = 8'hC9;
	localparam logic [7:0] OPX_IRQ_EXIT_JUMP = 8'h4D;
	localparam logic [7:0] OPX_NMI_EXIT_JUMP = 8'h45;
	localparam logic [7:0] OPX_RRD  = 8'h67;
	localparam logic [7:0] OPX_RLD  = 8'h6F;

	// opcode families: (op & mask) == pattern
	localparam logic [7:0] MASK_PAIR  = 8'hCF;
	localparam logic [7:0] PAT_ADD16  = 8'h09;
	localparam logic [7:0] PAT_ADC16  = 8'h4A;
	localparam logic [7:0] PAT_SBC16  = 8'h42;
	localparam logic [7:0] MASK_CC    = 8'hC7;
	localparam logic [7:0] PAT_JPCC   = 8'hC2;
	localparam logic [7:0] PAT_CALLCC = 8'hC4;
	localparam logic [7:0] PAT_RETCC  = 8'hC0;
	localparam logic [7:0] MASK_JRCC  = 8'hE7;
	localparam logic [7:0] PAT_JRCC   = 8'h20;

	// operand codes and bit-group codes of the bit prefix
	localparam logic [2:0] OPND_MEM = 3'h6;
	localparam logic [2:0] OPND_ACC = 3'h7;
	localparam logic [1:0] GRP_ROT  = 2'h0;
	localparam logic [1:0] GRP_TEST = 2'h1;
	localparam logic [1:0] GRP_CLR  = 2'h2;
	localparam logic [1:0] GRP_SET  = 2'h3;

	// index selection from the DD / FD prefix
	localparam logic [1:0] IDX_NONE = 2'h0;
	localparam logic [1:0] IDX_1    = 2'h1;
	localparam logic [1:0] IDX_2    = 2'h2;

	// sequencer states; four-state base so they sit in the packed state
	typedef enum logic [3:0] {ST_FETCH, ST_DISP, ST_OPCB, ST_OPLO, ST_OPHI,
		ST_MEMRD, ST_MEMWR, ST_PUSHH, ST_PUSHL, ST_POPL, ST_POPH} cbd_state_t;

	// 16-bit arithmetic kinds; four-state base so the kind can ride a net
	typedef enum logic [1:0] {A16_ADD, A16_ADC, A16_SBC} cbd_a16_t;

endpackage

`default_nettype wire

/* File: tb.sv */
// Purpose: scenario bench for the arithmetic, bit and branch core
// Assumes: each scenario restarts the core from reset at address 0
// Notes:   code is poked into memory while the core is held in reset
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        core_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [1:0]  lag = 2'h0;
	logic [15:0] bus_addr;
	logic [7:0]  bus_rdata, bus_wdata, acc_out, flags_out;
	logic        bus_rd, bus_wr, bus_ack, irq_exit_pulse, bad_op_pulse;
	int          exit_count, mismatches = 0, check_count = 0, bad_ops = 0;
	cbd_core i_cbd_core (.core_clk(core_clk), .rst_n(rst_n),
		.bus_rdata(bus_rdata), .bus_ack(bus_ack), .bus_addr(bus_addr),
		.bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
		.irq_exit_pulse(irq_exit_pulse), .bad_op_pulse(bad_op_pulse),
		.acc_out(acc_out), .flags_out(flags_out));
	cbd_mem i_cbd_mem (.core_clk(core_clk), .bus_addr(bus_addr),
		.bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
		.irq_exit_pulse(irq_exit_pulse), .lag(lag), .bus_ack(bus_ack),
		.bus_rdata(bus_rdata), .exit_count(exit_count));
	always #20 core_clk = ~core_clk;
	// opcodes outside the slice, counted for the skip check
	always @(posedge core_clk)
		if (bad_op_pulse === 1'b1) bad_ops <= bad_ops + 1;
	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic chk(input string w, input logic [15:0] e, g);
		check_count++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", w, e, g);
		end
	endtask
	// hold the core in reset for eight cycles
	task automatic hold(input logic [1:0] l);
		@(posedge core_clk);
		rst_n <= 1'b0;
		lag <= l;
		repeat (8) @(posedge core_clk);
	endtask
	task automatic put(input logic [15:0] a, input logic [95:0] v, int n);
		for (int k = 0; k < n; k++)
			i_cbd_mem.mem[a + 16'(k)] = v[8*(n-1-k) +: 8];
	endtask
	// bounded wait for a read strobe at a, sampled at the quiet edge;
	// a wait that runs out leaves the strobe or address check failing
	task automatic fetch(input logic [15:0] a);
		int n;
		n = 0;
		rst_n <= 1'b1;
		do begin
			@(negedge core_clk);
			n++;
		end while (!(bus_rd === 1'b1 && bus_addr === a) && n < 300);
		chk("fetch strobe", 16'h0001, {15'h0000, bus_rd});
		chk("fetch address", a, bus_addr);
	endtask
	task automatic mem_is(input logic [15:0] a, input logic [7:0] e);
		chk("memory byte", {8'h00, e}, {8'h00, i_cbd_mem.mem[a]});
	endtask
	task automatic s_jump();
		int b0;
		hold(2'h0);
		put(16'h0000, 48'hCA0020C33412, 6);
		fetch(16'h0003);
		fetch(16'h1234);
		b0 = bad_ops;
		fetch(16'h1235);
		chk("skipped opcode", 16'(b0 + 1), 16'(bad_ops));
	endtask
	task automatic s_rel();
		hold(2'h1);
		put(16'h0000, 16'h1810, 2);
		put(16'h0012, 16'h18F0, 2);
		fetch(16'h0012);
		fetch(16'h0004);
	endtask
	task automatic s_call();
		int e0;
		e0 = exit_count;
		hold(2'h2);
		put(16'h0000, 72'hCD0030CD0040CD0050, 9);
		put(16'h3000, 8'hC9, 1);
		put(16'h4000, 16'hED4D, 2);
		put(16'h5000, 16'hED45, 2);
		fetch(16'h3000);
		mem_is(16'hFFFE, 8'h00);
		mem_is(16'hFFFD, 8'h03);
		fetch(16'h0003);
		fetch(16'h4000);
		fetch(16'h0006);
		fetch(16'h5000);
		fetch(16'h0009);
		chk("exit count", 16'(e0 + 1), 16'(exit_count));
	endtask
	// index pairs as destination, self-source and jump source
	task automatic s_index();
		hold(2'h1);
		put(16'h0000, 64'hFD39DD39DD29FDE9, 8);
		fetch(16'hFFFF);
		chk("flags", 16'h0011, {8'h00, flags_out});
	endtask
	// shifts and rotates on the accumulator and on memory
	task automatic s_rot();
		hold(2'h0);
		put(16'h0000, 96'hCBFFCB2FCB07CB3FCB1618FE, 12);
		fetch(16'h0004);
		chk("acc", 16'h00C0, {8'h00, acc_out});
		chk("flags", 16'h0084, {8'h00, flags_out});
		fetch(16'h0006);
		chk("acc", 16'h0081, {8'h00, acc_out});
		chk("flags", 16'h0085, {8'h00, flags_out});
		fetch(16'h0008);
		chk("acc", 16'h0040, {8'h00, acc_out});
		chk("flags", 16'h0001, {8'h00, flags_out});
		fetch(16'h000A);
		mem_is(16'h0000, 8'h97);
		chk("flags", 16'h0081, {8'h00, flags_out});
	endtask
	task automatic s_arith();
		hold(2'h0);
		put(16'h0000, 48'hED42ED7A29E9, 6);
		fetch(16'h0002);
		chk("flags", 16'h0042, {8'h00, flags_out});
		fetch(16'h0004);
		chk("flags", 16'h0080, {8'h00, flags_out});
		fetch(16'hFFFE);
		chk("flags", 16'h0091, {8'h00, flags_out});
	endtask
	task automatic s_bit();
		hold(2'h1);
		put(16'h0000, 80'hCBC7CB47CB4FCBD6CB86, 10);
		put(16'h000A, 48'hDDCBFBDE18FE, 6);
		put(16'hFFFB, 8'h00, 1);
		fetch(16'h0004);
		chk("acc", 16'h0001, {8'h00, acc_out});
		chk("flags", 16'h0010, {8'h00, flags_out});
		fetch(16'h0006);
		chk("flags", 16'h0050, {8'h00, flags_out});
		fetch(16'h0008);
		mem_is(16'h0000, 8'hCF);
		fetch(16'h000A);
		mem_is(16'h0000, 8'hCE);
		fetch(16'h000E);
		mem_is(16'hFFFB, 8'h08);
	endtask
	task automatic s_digit();
		hold(2'h0);
		put(16'h0000, 48'hED6FED6718FE, 6);
		fetch(16'h0002);
		chk("acc", 16'h000E, {8'h00, acc_out});
		mem_is(16'h0000, 8'hD0);
		fetch(16'h0004);
		chk("flags", 16'h0044, {8'h00, flags_out});
		mem_is(16'h0000, 8'hED);
	endtask
	initial begin
		s_jump();
		s_rel();
		s_call();
		s_arith();
		s_index();
		s_bit();
		s_rot();
		s_digit();
		stop_test();
	end
endmodule
`default_nettype wire
